// ---- inc/rcd_pkg.sv ----
// Constants shared by the reset cause and debug force-reset logic.
package rcd_pkg;

	// Register addresses on the processor bus
	localparam logic [15:0] RCD_CAUSE_ADDR = 16'h1800;
	localparam logic [15:0] RCD_FORCE_ADDR = 16'h1801;

	// Field positions in the cause register
	localparam int RCD_BIT_POWER_ON   = 7;
	localparam int RCD_BIT_PIN        = 6;
	localparam int RCD_BIT_WATCHDOG   = 5;
	localparam int RCD_BIT_BAD_OPCODE = 4;
	localparam int RCD_BIT_BAD_ADDR   = 3;
	localparam int RCD_BIT_CLOCKGEN   = 2;
	localparam int RCD_BIT_LOW_VOLT   = 1;
	localparam int RCD_BIT_FORCE      = 0;

	// Values after reset, cause mask and read-back values
	localparam logic [7:0] RCD_CAUSE_POWER_ON_VAL = 8'h82;
	localparam logic [7:0] RCD_CAUSE_MASK         = 8'hFE;
	localparam logic [7:0] RCD_FORCE_READ_VAL     = 8'h00;
	localparam logic [7:0] RCD_RDATA_RESET_VAL    = 8'h00;

	// Address gaps that count as illegal accesses
	localparam logic [15:0] RCD_GAP0_LO = 16'h0470;
	localparam logic [15:0] RCD_GAP0_HI = 16'h17FF;
	localparam logic [15:0] RCD_GAP1_LO = 16'h1860;
	localparam logic [15:0] RCD_GAP1_HI = 16'hBFFF;

	// Timing of the internal reset pulse
	localparam int RCD_CLK_PERIOD_PS  = 8000;
	localparam int RCD_RESET_HOLD_NS  = 1000;
	localparam int RCD_RESET_HOLD_CYC =
		(RCD_RESET_HOLD_NS * 1000 + RCD_CLK_PERIOD_PS - 1) / RCD_CLK_PERIOD_PS;
	localparam int RCD_HOLD_W         = $clog2(RCD_RESET_HOLD_CYC + 1);

	typedef enum logic {
		RCD_RUN,
		RCD_HOLD
	} rcd_state_e;

endpackage

// ---- hdl/rcd_reset_cause.sv ----
// Reset cause capture, watchdog restart on write and debug-only forced reset.
module rcd_reset_cause
	import rcd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Asynchronous sources, synchronised here
	input  wire logic        power_on_i,
	input  wire logic        reset_pin_n_i,
	input  wire logic        low_voltage_i,
	// Same-clock sources
	input  wire logic        watchdog_timeout_i,
	input  wire logic        watchdog_enable_i,
	input  wire logic        bad_opcode_i,
	input  wire logic        stop_exec_i,
	input  wire logic        stop_allow_i,
	input  wire logic        enter_background_instr_i,
	input  wire logic        background_mode_allow_i,
	input  wire logic        clockgen_reset_req_i,
	input  wire logic        low_voltage_reset_enable_i,
	input  wire logic        low_voltage_stop_enable_i,
	// Processor bus, shared by user program and debug link
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        bus_rd_i,
	input  wire logic        bus_wr_i,
	input  wire logic [7:0]  bus_wdata_i,
	input  wire logic        bus_debug_i,
	output logic      [7:0]  bus_rdata_o,
	// System side
	output logic             mcu_reset_o,
	output logic             watchdog_restart_o,
	output logic      [7:0]  reset_cause_o
);

	logic                  power_on_s1_r;
	logic                  power_on_s2_r;
	logic                  pin_n_s1_r;
	logic                  pin_n_s2_r;
	logic                  low_volt_s1_r;
	logic                  low_volt_s2_r;
	rcd_state_e            state_r;
	logic [RCD_HOLD_W-1:0] hold_cnt_r;
	logic [7:0]            reset_cause_reg_r;
	logic [7:0]            rdata_r;
	logic                  restart_r;
	logic                  running;
	logic                  bus_acc;
	logic                  src_pin;
	logic                  src_watchdog;
	logic                  src_opcode;
	logic                  src_addr;
	logic                  src_clockgen;
	logic                  src_low_volt;
	logic                  src_power_on;
	logic                  force_reset_bit;
	logic                  any_src;
	logic [7:0]            cause_nxt;

	// Only the two gaps are decoded; register areas never match.
	function automatic logic is_illegal_addr(input logic [15:0] a);
		is_illegal_addr = ((a >= RCD_GAP0_LO) && (a <= RCD_GAP0_HI)) ||
			((a >= RCD_GAP1_LO) && (a <= RCD_GAP1_HI));
	endfunction

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			power_on_s1_r <= 1'b0;
			power_on_s2_r <= 1'b0;
			pin_n_s1_r    <= 1'b1;
			pin_n_s2_r    <= 1'b1;
			low_volt_s1_r <= 1'b0;
			low_volt_s2_r <= 1'b0;
		end else begin
			power_on_s1_r <= power_on_i;
			power_on_s2_r <= power_on_s1_r;
			pin_n_s1_r    <= reset_pin_n_i;
			pin_n_s2_r    <= pin_n_s1_r;
			low_volt_s1_r <= low_voltage_i;
			low_volt_s2_r <= low_volt_s1_r;
		end
	end

	assign running = (state_r == RCD_RUN);
	// Bus is dead while the processor sits in reset
	assign bus_acc = running && (bus_rd_i || bus_wr_i);

	assign src_power_on = power_on_s2_r;
	assign src_pin      = !pin_n_s2_r;
	assign src_watchdog = watchdog_timeout_i && watchdog_enable_i;
	// Opcode and address faults only exist while code runs
	assign src_opcode   = running && (bad_opcode_i ||
		(stop_exec_i && !stop_allow_i) ||
		(enter_background_instr_i && !background_mode_allow_i));
	assign src_addr     = bus_acc && is_illegal_addr(bus_addr_i);
	assign src_clockgen = clockgen_reset_req_i;
	assign src_low_volt = low_volt_s2_r && low_voltage_reset_enable_i &&
		low_voltage_stop_enable_i;

	assign force_reset_bit = running && bus_wr_i && bus_debug_i &&
		(bus_addr_i == RCD_FORCE_ADDR) && bus_wdata_i[RCD_BIT_FORCE];

	assign any_src = src_power_on || src_pin || src_watchdog || src_opcode ||
		src_addr || src_clockgen || src_low_volt;

	// New cause byte at the start of a reset; forced reset contributes no bit.
	always_comb begin
		cause_nxt = 8'h00;
		if (src_power_on) begin
			cause_nxt = RCD_CAUSE_POWER_ON_VAL;
		end else if (src_low_volt) begin
			cause_nxt[RCD_BIT_POWER_ON] = reset_cause_reg_r[RCD_BIT_POWER_ON];
			cause_nxt[RCD_BIT_LOW_VOLT] = 1'b1;
		end else begin
			cause_nxt[RCD_BIT_PIN]        = src_pin;
			cause_nxt[RCD_BIT_WATCHDOG]   = src_watchdog;
			cause_nxt[RCD_BIT_BAD_OPCODE] = src_opcode;
			cause_nxt[RCD_BIT_BAD_ADDR]   = src_addr;
			cause_nxt[RCD_BIT_CLOCKGEN]   = src_clockgen;
		end
	end

	// Reset pulse: held while any source stays active, then a fixed tail
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r    <= RCD_HOLD;
			hold_cnt_r <= RCD_HOLD_W'(RCD_RESET_HOLD_CYC);
		end else begin
			unique case (state_r)
				RCD_RUN: begin
					if (any_src || force_reset_bit) begin
						state_r    <= RCD_HOLD;
						hold_cnt_r <= RCD_HOLD_W'(RCD_RESET_HOLD_CYC);
					end
				end
				RCD_HOLD: begin
					if (any_src) begin
						hold_cnt_r <= RCD_HOLD_W'(RCD_RESET_HOLD_CYC);
					end else if (hold_cnt_r == RCD_HOLD_W'(1)) begin
						state_r <= RCD_RUN;
					end else begin
						hold_cnt_r <= hold_cnt_r - RCD_HOLD_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mcu_reset_o <= 1'b1;
		end else begin
			mcu_reset_o <= !(state_r == RCD_HOLD && !any_src && hold_cnt_r == RCD_HOLD_W'(1)) &&
				(state_r == RCD_HOLD || any_src || force_reset_bit);
		end
	end

	// Cause flags change only around reset; bus writes never reach them.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reset_cause_reg_r <= RCD_CAUSE_POWER_ON_VAL;
		end else if (running) begin
			if (any_src || force_reset_bit) begin
				reset_cause_reg_r <= cause_nxt & RCD_CAUSE_MASK;
			end
		end else if (src_power_on) begin
			reset_cause_reg_r <= RCD_CAUSE_POWER_ON_VAL;
		end else if (any_src) begin
			// Sources arriving during the pulse join the record
			reset_cause_reg_r <= reset_cause_reg_r | (cause_nxt & RCD_CAUSE_MASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= running && bus_wr_i && (bus_addr_i == RCD_CAUSE_ADDR);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= RCD_RDATA_RESET_VAL;
		end else if (bus_acc && bus_rd_i && bus_addr_i == RCD_CAUSE_ADDR) begin
			rdata_r <= reset_cause_reg_r & RCD_CAUSE_MASK;
		end else begin
			rdata_r <= RCD_FORCE_READ_VAL;
		end
	end

	assign bus_rdata_o        = rdata_r;
	assign watchdog_restart_o = restart_r;
	assign reset_cause_o      = reset_cause_reg_r;

endmodule

// ---- tb/rcd_properties.sv ----
// Port assertions for the reset cause block.
module rcd_props
	import rcd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic        bus_rd_i,
	input wire logic        bus_wr_i,
	input wire logic [7:0]  bus_wdata_i,
	input wire logic        bus_debug_i,
	input wire logic [7:0]  bus_rdata_o,
	input wire logic        mcu_reset_o,
	input wire logic        watchdog_restart_o,
	input wire logic [7:0]  reset_cause_o
);
	timeunit 1ns / 1ps;
	logic run;
	logic cw;
	assign run = !mcu_reset_o;
	assign cw  = run && bus_wr_i && bus_addr_i == RCD_CAUSE_ADDR;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_restart_pulse: assert property (cw |=> watchdog_restart_o)
		else $error("restart missing");
	a_restart_quiet: assert property (!cw |=> !watchdog_restart_o)
		else $error("stray restart");
	a_cause_stable: assert property (run |=> mcu_reset_o || $stable(reset_cause_o))
		else $error("cause moved");
	a_bit0_zero: assert property (!reset_cause_o[0])
		else $error("cause bit0 set");
	a_cause_read: assert property (
		run && bus_rd_i && bus_addr_i == RCD_CAUSE_ADDR |=> bus_rdata_o == $past(reset_cause_o))
		else $error("cause read wrong");
	a_force_reads_zero: assert property (
		run && bus_rd_i && bus_addr_i == RCD_FORCE_ADDR |=> bus_rdata_o == 8'h00)
		else $error("force read nonzero");
	a_debug_force: assert property (
		run && bus_wr_i && bus_debug_i && bus_addr_i == RCD_FORCE_ADDR && bus_wdata_i[0]
		|=> mcu_reset_o [*8]) else $error("force reset missing");
	a_gap_reset: assert property (
		run && (bus_rd_i || bus_wr_i) && bus_addr_i inside {[RCD_GAP0_LO:RCD_GAP0_HI],
		[RCD_GAP1_LO:RCD_GAP1_HI]} |=> mcu_reset_o && reset_cause_o[3]) else $error("gap");
endmodule

bind rcd_reset_cause rcd_props u_props (.*);

// ---- tb/rcd_debug_host.sv ----
// Debug host model issuing byte writes over the debug link.
module rcd_debug_host (
	input  wire logic        clk_i,
	output logic             wr_o,
	output logic      [15:0] addr_o,
	output logic      [7:0]  data_o
);
	timeunit 1ns / 1ps;
	initial wr_o = 1'h0;
	// Address and data matter only while wr_o is high
	task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_o = 1'h1;
		addr_o = a;
		data_o = d;
		@(negedge clk_i);
		wr_o = 1'h0;
	endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the reset cause block.
module tb;
	timeunit 1ns / 1ps;
	import rcd_pkg::*;
	logic        clk_i   = 1'h0;
	logic        reset_i = 1'h1;
	logic [12:0] c       = 13'h0000;
	logic        u_rd    = 1'h0;
	logic        u_wr    = 1'h0;
	logic [15:0] u_addr  = 16'h0000;
	logic [7:0]  u_wd    = 8'h00;
	logic        h_wr, mrst, wdr;
	logic [15:0] h_addr;
	logic [7:0]  h_wd, rdata, d, cause;
	int          num_errors, check_count, cycles;
	always #4 clk_i = ~clk_i;
	rcd_debug_host host (.clk_i(clk_i), .wr_o(h_wr), .addr_o(h_addr), .data_o(h_wd));
	rcd_reset_cause dut (.clk_i(clk_i), .reset_i(reset_i), .power_on_i(c[12]),
		.reset_pin_n_i(!c[0]), .low_voltage_i(c[9]), .watchdog_timeout_i(c[1]),
		.watchdog_enable_i(c[2]), .bad_opcode_i(c[3]), .stop_exec_i(c[4]),
		.stop_allow_i(c[5]), .enter_background_instr_i(c[6]),
		.background_mode_allow_i(c[7]), .clockgen_reset_req_i(c[8]),
		.low_voltage_reset_enable_i(c[10]), .low_voltage_stop_enable_i(c[11]),
		.bus_addr_i(h_wr ? h_addr : u_addr), .bus_rd_i(u_rd), .bus_wr_i(u_wr | h_wr),
		.bus_wdata_i(h_wr ? h_wd : u_wd), .bus_debug_i(h_wr), .bus_rdata_o(rdata),
		.mcu_reset_o(mrst), .watchdog_restart_o(wdr), .reset_cause_o(cause));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] w);
		@(negedge clk_i);
		{u_rd, u_wr, u_addr, u_wd} = {!wr, wr, a, w};
		@(negedge clk_i);
		{u_rd, u_wr} = 2'h0;
		d = rdata;
	endtask
	// Reset pulse is 125 cycles plus synchroniser delay
	task automatic wait_run();
		for (int n = 0; n < 300 && mrst !== 1'h0; n++)
			@(negedge clk_i);
		check({7'h00, mrst}, 8'h00);
	endtask
	task automatic src(input logic [12:0] v, input logic [15:0] a, input logic hit,
		input logic [7:0] exp);
		c = v;
		bus(1'h0, a, 8'h00);
		repeat (3) @(negedge clk_i);
		check({7'h00, mrst}, {7'h00, hit});
		c = 13'h0000;
		wait_run();
		bus(1'h0, RCD_CAUSE_ADDR, 8'h00);
		check(d, exp);
		check(cause, exp);
		$display("test %h %h done", v, a);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 10000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (4) @(negedge clk_i);
		reset_i = 1'h0;
		wait_run();
		bus(1'h0, RCD_CAUSE_ADDR, 8'h00);
		check(d, 8'h82);
		bus(1'h1, RCD_CAUSE_ADDR, 8'hFF);
		check({7'h00, wdr}, 8'h01);
		bus(1'h0, RCD_CAUSE_ADDR, 8'h00);
		check(d, 8'h82);
		bus(1'h1, RCD_FORCE_ADDR, 8'h01);
		bus(1'h0, RCD_FORCE_ADDR, 8'h00);
		check(d, 8'h00);
		check({7'h00, mrst}, 8'h00);
		host.write_byte(RCD_FORCE_ADDR, 8'h01);
		wait_run();
		bus(1'h0, RCD_CAUSE_ADDR, 8'h00);
		check(d, 8'h00);
		$display("test registers done");
		src(13'h0001, RCD_FORCE_ADDR, 1'h1, 8'h40);
		src(13'h0006, RCD_FORCE_ADDR, 1'h1, 8'h20);
		src(13'h0002, RCD_FORCE_ADDR, 1'h0, 8'h20);
		src(13'h0008, RCD_FORCE_ADDR, 1'h1, 8'h10);
		src(13'h0100, RCD_FORCE_ADDR, 1'h1, 8'h04);
		src(13'h0000, 16'h1860, 1'h1, 8'h08);
		src(13'h0010, RCD_FORCE_ADDR, 1'h1, 8'h10);
		src(13'h0030, RCD_FORCE_ADDR, 1'h0, 8'h10);
		src(13'h0000, 16'hBFFF, 1'h1, 8'h08);
		src(13'h0000, 16'h17FF, 1'h1, 8'h08);
		src(13'h0040, RCD_FORCE_ADDR, 1'h1, 8'h10);
		src(13'h00C0, RCD_FORCE_ADDR, 1'h0, 8'h10);
		src(13'h0600, RCD_FORCE_ADDR, 1'h0, 8'h10);
		src(13'h0E00, RCD_FORCE_ADDR, 1'h1, 8'h02);
		src(13'h1000, RCD_FORCE_ADDR, 1'h1, 8'h82);
		src(13'h0E00, RCD_FORCE_ADDR, 1'h1, 8'h82);
		src(13'h0000, 16'h0470, 1'h1, 8'h08);
		src(13'h0000, 16'h1802, 1'h0, 8'h08);
		src(13'h0000, 16'hC000, 1'h0, 8'h08);
		stop_test();
	end
endmodule
